// >>> rtl/sif_deb.sv
// One-channel edge debounce with separate falling and rising enables.
// Assumes smp_in is a one-cycle strobe and raw_in is already synchronised.
`timescale 1ns/1ps
`default_nettype none
module sif_deb (
   input  wire logic ref_clk_in,   // System clock
   input  wire logic rst_n_in,     // Sync reset, low
   input  wire logic smp_in,       // Sample strobe
   input  wire logic raw_in,       // Synchronised level
   input  wire logic fall_en_in,   // Filter high-to-low
   input  wire logic rise_en_in,   // Filter low-to-high
   output logic      lvl_out       // Accepted level
);
   typedef struct packed {
      logic       lvl;
      logic [1:0] cnt;
   } sif_deb_st_t;
   sif_deb_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (smp_in) begin
         if (raw_in == s_q.lvl) begin
            s_d.cnt = 2'h0;
         end else if (raw_in ? rise_en_in : fall_en_in) begin
            if (s_q.cnt == sif_pkg::DEB_LAST) begin
               s_d.lvl = raw_in;
               s_d.cnt = 2'h0;
            end else begin
               s_d.cnt = s_q.cnt + 2'h1;
            end
         end else begin
            s_d.lvl = raw_in;
            s_d.cnt = 2'h0;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign lvl_out = s_q.lvl;

   property p_deb_three;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      $changed(s_q.lvl) && (s_q.lvl ? $past(rise_en_in) : $past(fall_en_in))
         |-> $past(s_q.cnt) == sif_pkg::DEB_LAST;
   endproperty
   a_deb_three: assert property (p_deb_three) else $error("filtered change too early");

   property p_deb_pass;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      smp_in && raw_in && !s_q.lvl && !rise_en_in |=> lvl_out;
   endproperty
   a_deb_pass: assert property (p_deb_pass) else $error("unfiltered rise not taken");

   property p_deb_restart;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      smp_in && (raw_in == s_q.lvl) |=> s_q.cnt == 2'h0 && $stable(lvl_out);
   endproperty
   a_deb_restart: assert property (p_deb_restart) else $error("bounce did not restart");
endmodule // sif_deb
`default_nettype wire

// >>> rtl/sif_pkg.sv
// Constants and types for the safety input filter block.
// Assumes one 25 MHz clock and a plain register port.
package sif_pkg;
   localparam int unsigned NCH         = 8;
   localparam int unsigned NPAIR       = 4;
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned TICK_MS     = 4;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned DEB_SAMPLES = 3;
   localparam logic [1:0]  DEB_LAST    = 2'(DEB_SAMPLES - 1);
   localparam int unsigned SYNC_MAX_MS_I = 30000;
   localparam logic [14:0] SYNC_MAX_MS = 15'(SYNC_MAX_MS_I);
   localparam logic [12:0] SYNC_MAX_TK = 13'((SYNC_MAX_MS_I + TICK_MS - 1) / TICK_MS);
   localparam logic [15:0] SYNC_RND    = 16'(TICK_MS - 1);
   localparam int unsigned TEST_PERIOD_MS = 64;
   localparam int unsigned TP_TICKS    = TEST_PERIOD_MS / TICK_MS;
   localparam logic [3:0]  TP_LAST     = 4'(TP_TICKS - 1);
   localparam logic [3:0]  TP_GAP_A    = 4'h0;
   localparam logic [3:0]  TP_GAP_B    = 4'(TP_TICKS / 2);
   // Register offsets
   localparam logic [3:0]  ADDR_TEST   = 4'h0;
   localparam logic [3:0]  ADDR_FILT   = 4'h1;
   localparam logic [3:0]  ADDR_PAIR   = 4'h2;
   localparam logic [1:0]  ADDR_SYNC_HI = 2'h1;
   localparam logic [3:0]  ADDR_STAT   = 4'h8;
   localparam logic [3:0]  ADDR_PSTAT  = 4'h9;
   // Field positions
   localparam int unsigned F_LO        = 0;
   localparam int unsigned F_HI        = 8;
   localparam int unsigned F_DISC      = 4;
   localparam logic [15:0] RST_VAL     = 16'h0000;
   // Hardware revision codes, values arbitrary
   localparam logic [7:0]  HW_REV_DEF  = 8'h02;
   localparam logic [7:0]  MIN_REV_DEF = 8'h02;
   typedef enum logic [1:0] {SIF_INACT, SIF_DISC, SIF_ACT, SIF_ERR} sif_pair_t;
endpackage

// >>> rtl/sif_tick.sv
// Evaluation strobe divider: one-cycle pulse every CYCLES clocks.
// Assumes a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sif_tick #(
   parameter int unsigned CYCLES = sif_pkg::TICK_CYCLES
) (
   input  wire logic ref_clk_in,   // System clock
   input  wire logic rst_n_in,     // Sync reset, low
   output logic      tick_out      // Evaluation strobe
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } sif_tick_st_t;
   sif_tick_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == LAST) begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + W'(1);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_out = s_q.tick;

   property p_tick_gap;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      tick_out |=> !tick_out [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick spacing too short");
endmodule // sif_tick
`default_nettype wire

// >>> rtl/sif_top.sv
// Safety input conditioning: sampling, debounce, two-channel pairs, test pulses.
// Assumes sensor pins are asynchronous and registers sit on a plain port.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sif_top #(
   parameter int unsigned TICK_CYCLES = sif_pkg::TICK_CYCLES,
   parameter logic [7:0]  HW_REV      = sif_pkg::HW_REV_DEF,
   parameter logic [7:0]  MIN_REV     = sif_pkg::MIN_REV_DEF
) (
   input  wire logic        ref_clk_in,    // 25 MHz clock
   input  wire logic        rst_n_in,      // Sync reset, low
   input  wire logic [3:0]  addr_in,       // Register index
   input  wire logic [15:0] wr_data_in,    // Write data
   input  wire logic        wr_en_in,      // Write strobe
   input  wire logic        rd_en_in,      // Read strobe
   output logic      [15:0] rd_data_out,   // Read data, next cycle
   input  wire logic [7:0]  sens_in,       // Sensor pins
   output logic      [7:0]  test_out,      // Test pulse outputs
   output logic      [7:0]  chan_out,      // Filtered channels
   output logic      [3:0]  pair_act_out,  // Pair active
   output logic      [3:0]  pair_err_out   // Pair error latched
);
   typedef struct packed {
      logic [7:0]                s1;
      logic [7:0]                s2;
      logic [7:0]                tested;
      logic [7:0]                tp_dis;
      logic [7:0]                fall_en;
      logic [7:0]                rise_en;
      logic [3:0]                pair_en;
      logic [3:0]                disc;
      logic [3:0][14:0]          sync_ms;
      sif_pkg::sif_pair_t [3:0]  pst;
      logic [3:0][12:0]          tmr;
      logic [3:0]                blk;
      logic [3:0]                err;
      logic [7:0]                fault;
      logic [7:0]                chan;
      logic [3:0]                tp_cnt;
      logic [7:0]                tout;
      logic [15:0]               rdata;
   } sif_top_st_t;
   sif_top_st_t s_q, s_d;

   logic       tick;
   logic [7:0] tp_on;
   logic [7:0] gap_c;
   logic [7:0] smp;
   logic [7:0] f_fall;
   logic [7:0] f_rise;
   logic [7:0] flt;

   function automatic logic [12:0] sync_ticks(input logic [14:0] ms);
      logic [14:0] c;
      logic [15:0] r;
      c = (ms > sif_pkg::SYNC_MAX_MS) ? sif_pkg::SYNC_MAX_MS : ms;
      r = {1'b0, c} + sif_pkg::SYNC_RND;
      return r[14:2];
   endfunction

   function automatic logic gap_at(input logic [3:0] cnt, input logic odd);
      return odd ? (cnt == sif_pkg::TP_GAP_B) : (cnt == sif_pkg::TP_GAP_A);
   endfunction

   sif_tick #(
      .CYCLES     (TICK_CYCLES)
   ) u_tick (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .tick_out   (tick)
   );

   // Old revisions ignore the per-output disable
   assign tp_on = (HW_REV >= MIN_REV) ? ~s_q.tp_dis : 8'hFF;

   for (genvar i = 0; i < sif_pkg::NCH; i++) begin : g_ch
      // Two sources: even outputs on one, odd on the other
      assign gap_c[i] = gap_at(s_q.tp_cnt, i[0]) & tp_on[i];
      // Hold the sample while a tested input sits in its gap
      assign smp[i] = tick & ~(gap_c[i] & s_q.tested[i]);
      if (i[0]) begin : g_odd
         localparam int L = i - 1;
         assign f_fall[i] = (s_q.pair_en[i/2] && s_q.disc[i/2]) ? s_q.rise_en[L] : s_q.fall_en[i];
         assign f_rise[i] = (s_q.pair_en[i/2] && s_q.disc[i/2]) ? s_q.fall_en[L] : s_q.rise_en[i];
      end else begin : g_lead
         assign f_fall[i] = s_q.fall_en[i];
         assign f_rise[i] = s_q.rise_en[i];
      end
      sif_deb u_deb (
         .ref_clk_in (ref_clk_in),
         .rst_n_in   (rst_n_in),
         .smp_in     (smp[i]),
         .raw_in     (s_q.s2[i]),
         .fall_en_in (f_fall[i]),
         .rise_en_in (f_rise[i]),
         .lvl_out    (flt[i])
      );
   end

   always_comb begin
      logic        a;
      logic        b;
      logic [12:0] lim;
      logic [12:0] tnx;
      a = 1'b0;
      b = 1'b0;
      lim = 13'h0;
      tnx = 13'h0;
      s_d = s_q;
      s_d.s1 = sens_in;
      s_d.s2 = s_q.s1;
      s_d.rdata = 16'h0000;
      if (tick) begin
         s_d.tp_cnt = (s_q.tp_cnt == sif_pkg::TP_LAST) ? 4'h0 : s_q.tp_cnt + 4'h1;
      end
      for (int i = 0; i < sif_pkg::NCH; i++) begin
         s_d.tout[i] = ~(gap_at(s_d.tp_cnt, i[0]) & tp_on[i]);
         if (!s_q.tested[i] || !tp_on[i]) begin
            s_d.fault[i] = 1'b0;
         end else if (tick && gap_c[i]) begin
            s_d.fault[i] = s_q.s2[i];
         end
      end
      // A detected short forces the channel low
      s_d.chan = flt & ~s_d.fault;
      for (int p = 0; p < sif_pkg::NPAIR; p++) begin
         a = s_q.chan[2*p];
         b = s_q.chan[2*p+1] ^ s_q.disc[p];
         lim = sync_ticks(s_q.sync_ms[p]);
         tnx = s_q.tmr[p] + 13'h1;
         if (!s_q.pair_en[p]) begin
            s_d.pst[p] = sif_pkg::SIF_INACT;
            s_d.tmr[p] = 13'h0;
            s_d.blk[p] = 1'b0;
            s_d.err[p] = 1'b0;
         end else if (tick) begin
            unique case ({a, b})
               2'b00: begin
                  s_d.pst[p] = sif_pkg::SIF_INACT;
                  s_d.tmr[p] = 13'h0;
                  s_d.blk[p] = 1'b0;
                  s_d.err[p] = 1'b0;
               end
               2'b11: begin
                  if (s_q.pst[p] == sif_pkg::SIF_DISC || s_q.pst[p] == sif_pkg::SIF_INACT) begin
                     if (s_q.blk[p]) begin
                        s_d.pst[p] = sif_pkg::SIF_ERR;  // Sequence error
                        s_d.err[p] = 1'b1;
                     end else begin
                        s_d.pst[p] = sif_pkg::SIF_ACT;
                        s_d.blk[p] = 1'b1;
                     end
                     s_d.tmr[p] = 13'h0;
                  end
               end
               default: begin
                  if (s_q.pst[p] == sif_pkg::SIF_INACT || s_q.pst[p] == sif_pkg::SIF_ACT) begin
                     s_d.pst[p] = sif_pkg::SIF_DISC;
                     s_d.tmr[p] = 13'h0;
                  end else if (s_q.pst[p] == sif_pkg::SIF_DISC && lim != 13'h0) begin
                     if (tnx >= lim) begin
                        s_d.pst[p] = sif_pkg::SIF_ERR;
                        s_d.err[p] = 1'b1;
                     end else begin
                        s_d.tmr[p] = tnx;
                     end
                  end
               end
            endcase
         end
      end
      if (wr_en_in) begin
         if (addr_in == sif_pkg::ADDR_TEST) begin
            s_d.tested = wr_data_in[sif_pkg::F_LO +: 8];
            s_d.tp_dis = wr_data_in[sif_pkg::F_HI +: 8];
         end
         if (addr_in == sif_pkg::ADDR_FILT) begin
            s_d.fall_en = wr_data_in[sif_pkg::F_LO +: 8];
            s_d.rise_en = wr_data_in[sif_pkg::F_HI +: 8];
         end
         if (addr_in == sif_pkg::ADDR_PAIR) begin
            s_d.pair_en = wr_data_in[sif_pkg::F_LO +: 4];
            s_d.disc = wr_data_in[sif_pkg::F_DISC +: 4];
         end
         if (addr_in[3:2] == sif_pkg::ADDR_SYNC_HI) begin
            s_d.sync_ms[addr_in[1:0]] = wr_data_in[14:0];
         end
      end
      if (rd_en_in) begin
         if (addr_in == sif_pkg::ADDR_TEST) begin
            s_d.rdata = {s_q.tp_dis, s_q.tested};
         end
         if (addr_in == sif_pkg::ADDR_FILT) begin
            s_d.rdata = {s_q.rise_en, s_q.fall_en};
         end
         if (addr_in == sif_pkg::ADDR_PAIR) begin
            s_d.rdata = {8'h00, s_q.disc, s_q.pair_en};
         end
         if (addr_in[3:2] == sif_pkg::ADDR_SYNC_HI) begin
            s_d.rdata = {1'b0, s_q.sync_ms[addr_in[1:0]]};
         end
         if (addr_in == sif_pkg::ADDR_STAT) begin
            s_d.rdata = {s_q.fault, s_q.chan};
         end
         if (addr_in == sif_pkg::ADDR_PSTAT) begin
            s_d.rdata = {s_q.pst, pair_err_out, pair_act_out};
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data_out = s_q.rdata;
   assign test_out = s_q.tout;
   assign chan_out = s_q.chan;
   for (genvar p = 0; p < sif_pkg::NPAIR; p++) begin : g_po
      assign pair_act_out[p] = (s_q.pst[p] == sif_pkg::SIF_ACT);
      assign pair_err_out[p] = s_q.err[p];

      property p_err_clr;
         @(posedge ref_clk_in) disable iff (!rst_n_in)
         $fell(s_q.err[p]) && $past(s_q.pair_en[p]) |-> s_q.pst[p] == sif_pkg::SIF_INACT;
      endproperty
      a_err_clr: assert property (p_err_clr) else $error("error cleared outside inactive");

      property p_no_tmr;
         @(posedge ref_clk_in) disable iff (!rst_n_in)
         s_q.sync_ms[p] == 15'h0 && $past(s_q.sync_ms[p]) == 15'h0 |-> s_q.tmr[p] == 13'h0;
      endproperty
      a_no_tmr: assert property (p_no_tmr) else $error("timer ran with sync off");

      property p_round;
         @(posedge ref_clk_in) disable iff (!rst_n_in)
         s_q.sync_ms[p] != 15'h0 && s_q.sync_ms[p] <= sif_pkg::SYNC_MAX_MS
            |-> {1'b0, sync_ticks(s_q.sync_ms[p]), 2'b00} >= {1'b0, s_q.sync_ms[p]}
             && {1'b0, sync_ticks(s_q.sync_ms[p]), 2'b00} < {1'b0, s_q.sync_ms[p]} + 16'h0004;
      endproperty
      a_round: assert property (p_round) else $error("sync time not rounded up");

      property p_range;
         @(posedge ref_clk_in) disable iff (!rst_n_in)
         s_q.sync_ms[p] != 15'h0 |-> sync_ticks(s_q.sync_ms[p]) >= 13'h1
            && sync_ticks(s_q.sync_ms[p]) <= sif_pkg::SYNC_MAX_TK;
      endproperty
      a_range: assert property (p_range) else $error("sync limit out of range");

      property p_tmr_bound;
         @(posedge ref_clk_in) disable iff (!rst_n_in)
         s_q.pst[p] == sif_pkg::SIF_DISC && sync_ticks(s_q.sync_ms[p]) != 13'h0
            |-> s_q.tmr[p] < sync_ticks(s_q.sync_ms[p]);
      endproperty
      a_tmr_bound: assert property (p_tmr_bound) else $error("discrepancy past sync time");
   end

   property p_share;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      $past(tp_on) == 8'hFF && tp_on == 8'hFF |-> test_out == {4{test_out[1:0]}};
   endproperty
   a_share: assert property (p_share) else $error("more than two pulse sources");

   property p_old_rev;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      HW_REV < MIN_REV && $stable(s_q.tp_cnt) && s_q.tp_cnt == sif_pkg::TP_GAP_A
         |-> (test_out & 8'h55) == 8'h00;
   endproperty
   a_old_rev: assert property (p_old_rev) else $error("old revision skipped a pulse");

   property p_pulse;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      tick && s_q.tp_cnt == sif_pkg::TP_LAST && tp_on[0] |=> !test_out[0] ##1 !test_out[0];
   endproperty
   a_pulse: assert property (p_pulse) else $error("test output did not pulse");

   property p_short;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      tick && gap_c[4] && s_q.tested[4] && s_q.s2[4] |=> !chan_out[4] && s_q.fault[4];
   endproperty
   a_short: assert property (p_short) else $error("short not forced low");
endmodule // sif_top
`default_nettype wire

// >>> tb/sif_sensor.sv
// Sensor side model: contacts, wiring shorts to supply, test loop-back.
// Assumes tested contacts are fed from the module's test outputs.
`timescale 1ns/1ps
`default_nettype none
module sif_sensor (
   input  wire logic [7:0] contact_in,  // Contact closed
   input  wire logic [7:0] short_in,    // Wiring shorted to supply
   input  wire logic [7:0] tested_in,   // Contact fed by test output
   input  wire logic [7:0] test_in,     // Module test outputs
   output logic      [7:0] sens_out     // Module sensor pins
);
   // Closed tested contact passes the test pulse; a short overrides it
   assign sens_out = short_in | (contact_in & (test_in | ~tested_in));
endmodule // sif_sensor
`default_nettype wire

// >>> tb/sif_top_test.sv
// Self-checking bench: register tasks and timed checks on channel and pair outputs.
// Assumes sif_pkg, sif_top and sif_sensor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sif_top_test;
   localparam int TC = 16;
   logic        clk;
   logic        rst_n;
   logic [3:0]  addr;
   logic [15:0] wdat;
   logic        wr;
   logic        rd;
   logic [15:0] rdat;
   logic [7:0]  sens, test, chan, contact, short_hi, tested;
   logic [3:0]  act, err;
   logic [23:0] mon;
   logic [3:0]  ra [11] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h3, 4'hF};
   int          fail_count = 0;
   int          checks = 0;
   int          n, a, b, c, d, e;
   logic [7:0]  test_old;
   assign mon = {test, err, act, chan};
   always #20 clk = ~clk;
   sif_top #(.TICK_CYCLES(TC)) dut (.ref_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wdat),
      .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdat), .sens_in(sens), .test_out(test), .chan_out(chan),
      .pair_act_out(act), .pair_err_out(err));
   sif_sensor sensor (.contact_in(contact), .short_in(short_hi), .tested_in(tested), .test_in(test),
      .sens_out(sens));
   // Older revision: per-output pulse disable must be ignored
   sif_top #(.TICK_CYCLES(TC), .HW_REV(8'h01)) dut_old (.ref_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
      .wr_data_in(wdat), .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(), .sens_in(sens), .test_out(test_old),
      .chan_out(), .pair_act_out(), .pair_err_out());
   task automatic close_out;
      if (fail_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rng(input string nm, input int lo, input int hi, input int v);
      checks++;
      if (v < lo || v > hi) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, v);
      end
   endtask
   task automatic wreg(input logic [3:0] ad, input logic [15:0] dt);
      @(posedge clk);
      addr <= ad;
      wdat <= dt;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] ad, input logic [15:0] exp, input string nm);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(nm, exp, rdat);
   endtask
   task automatic setc(input logic [7:0] m, input logic [7:0] v);
      @(posedge clk);
      contact <= (contact & ~m) | v;
   endtask
   // Bounded wait for one monitored bit; returns the cycles taken
   task automatic wt(input int i, input logic v, input int mx, output int cnt);
      cnt = 0;
      checks++;
      while (mon[i] !== v) begin
         @(posedge clk);
         #1;
         cnt++;
         if (cnt > mx) begin
            fail_count++;
            $display("CHECK FAILED monitor bit %0d expected %b seen %b", i, v, mon[i]);
            close_out();
         end
      end
   endtask
   task automatic hold(input int i, input logic v, input int cy);
      checks++;
      repeat (cy) begin
         @(posedge clk);
         #1;
         if (mon[i] !== v) begin
            fail_count++;
            $display("CHECK FAILED monitor bit %0d expected %b seen %b", i, v, mon[i]);
            return;
         end
      end
   endtask
   // One full test period: low cycles per output and source overlaps
   task automatic pulses(output int l0, output int l1, output int l2, output int bad, output int lo);
      l0 = 0;
      l1 = 0;
      l2 = 0;
      bad = 0;
      lo = 0;
      repeat (16 * TC) begin
         @(posedge clk);
         #1;
         l0 += int'(test[0] === 1'b0);
         l1 += int'(test[1] === 1'b0);
         l2 += int'(test[2] === 1'b0);
         bad += int'(test[2] !== test[6] || test[1] !== test[7] || (test[2] === 1'b0 && test[1] === 1'b0));
         lo += int'(test_old[0] === 1'b0);
      end
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      addr = 4'h0;
      wdat = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      contact = 8'h00;
      short_hi = 8'h00;
      tested = 8'h00;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ra[k]) begin
         rreg(ra[k], 16'h0000, "reset value");
      end
      wreg(4'h4, 16'hFFFF);
      rreg(4'h4, 16'h7FFF, "sync width");
      wreg(4'hF, 16'hFFFF);
      rreg(4'hF, 16'h0000, "unmapped");
      wreg(4'h8, 16'hFFFF);
      rreg(4'h8, 16'h0000, "status read only");
      wreg(4'h4, 16'h0000);
      setc(8'h01, 8'h01);
      wt(0, 1'b1, TC + 8, n);
      wreg(4'h1, 16'h0200);
      setc(8'h02, 8'h02);
      wt(1, 1'b1, 4 * TC, n);
      rng("rise filter delay", 2 * TC, 3 * TC + 6, n);
      setc(8'h02, 8'h00);
      wt(1, 1'b0, TC + 8, n);
      // Bounce during confirmation
      wreg(4'h1, 16'h0201);
      setc(8'h01, 8'h00);
      repeat (TC) @(posedge clk);
      contact[0] <= 1'b1;
      repeat (TC) @(posedge clk);
      contact[0] <= 1'b0;
      hold(0, 1'b1, 2 * TC);
      wt(0, 1'b0, 2 * TC, n);
      // Equivalent pair 0, 5 ms rounds up to two ticks
      wreg(4'h1, 16'h0000);
      wreg(4'h4, 16'h0005);
      wreg(4'h2, 16'h0001);
      setc(8'h01, 8'h01);
      wt(0, 1'b1, 2 * TC, n);
      wt(12, 1'b1, 4 * TC, n);
      rng("sync timeout", 2 * TC + 4, 3 * TC + 4, n);
      rreg(4'h9, 16'h0310, "pair status");
      setc(8'h02, 8'h02);
      hold(12, 1'b1, 3 * TC);
      setc(8'h03, 8'h00);
      wt(12, 1'b0, 4 * TC, n);
      wreg(4'h4, 16'h0000);
      setc(8'h03, 8'h03);
      wt(8, 1'b1, 4 * TC, n);
      setc(8'h02, 8'h00);
      hold(12, 1'b0, 10 * TC);
      setc(8'h02, 8'h02);
      wt(12, 1'b1, 4 * TC, n);
      hold(8, 1'b0, 2 * TC);
      setc(8'h03, 8'h00);
      wt(12, 1'b0, 4 * TC, n);
      // Discrepant pair 1, rising filter on the lead only
      wreg(4'h1, 16'h0400);
      setc(8'h08, 8'h08);
      wreg(4'h2, 16'h0022);
      repeat (3 * TC) @(posedge clk);
      setc(8'h04, 8'h04);
      wt(2, 1'b1, 4 * TC, n);
      rng("lead filter delay", 2 * TC, 3 * TC + 6, n);
      setc(8'h08, 8'h00);
      wt(9, 1'b1, 5 * TC, n);
      rng("complement filter delay", 3 * TC, 4 * TC + 6, n);
      wreg(4'h2, 16'h0000);
      wreg(4'h1, 16'h0000);
      setc(8'hFF, 8'h00);
      pulses(a, b, c, d, e);
      rng("even pulse cycles", TC, TC, a);
      rng("odd pulse cycles", TC, TC, b);
      rng("shared sources", 0, 0, d);
      wreg(4'h0, 16'h0100);
      pulses(a, b, c, d, e);
      rng("disabled output", 0, 0, a);
      rng("enabled output", TC, TC, c);
      rng("old revision pulse", TC, TC, e);
      // Tested input 4 with a short to supply
      wreg(4'h0, 16'h0010);
      tested <= 8'h10;
      // Start just after a gap so the short is first seen high
      wt(20, 1'b0, 17 * TC, n);
      wt(20, 1'b1, 2 * TC, n);
      @(posedge clk);
      short_hi <= 8'h10;
      wt(4, 1'b1, 2 * TC + 8, n);
      wt(4, 1'b0, 17 * TC, n);
      rreg(4'h8, 16'h1000, "fault flag");
      @(posedge clk);
      short_hi <= 8'h00;
      setc(8'h10, 8'h10);
      wt(4, 1'b1, 20 * TC, n);
      wt(20, 1'b0, 17 * TC, n);
      wt(20, 1'b1, 2 * TC, n);
      @(posedge clk);
      contact[4] <= 1'b0;
      short_hi <= 8'h10;
      hold(4, 1'b1, 8 * TC);
      wt(4, 1'b0, 10 * TC, n);
      close_out();
   end
endmodule // sif_top_test
`default_nettype wire
